// ---- core/hpr_pkg.sv ----
/*
 * Constants shared by the hot-plug receiver: register indexes, field
 * positions, reset values, event codes and timing counts.
 * Assumes a 10 MHz core clock and a 32-bit AHB-Lite register bus.
 */
package hpr_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_PERIOD_NS = 10000;
    localparam int TICK_CYC = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
    localparam int TICK_US = TICK_PERIOD_NS / 1000;
    localparam int PLUG_LOSS_US = 2000;
    localparam int PLUG_LOSS_TICKS = (PLUG_LOSS_US + TICK_US - 1) / TICK_US;
    localparam int RUN_W = 16;

    // Bus
    localparam int DATA_W = 32;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int HTRANS_ACTIVE_BIT = 1;

    // Register indexes; byte address is four times the index
    localparam logic [11:0] IDX_CTRL = 12'hC00;
    localparam logic [11:0] IDX_FLAGS = 12'hC01;
    localparam logic [11:0] IDX_MASK = 12'hC02;
    localparam logic [11:0] IDX_QUEUE = 12'hC03;
    localparam logic [11:0] IDX_PULSE_MIN = 12'hC04;
    localparam logic [11:0] IDX_PULSE_MAX = 12'hC05;
    localparam logic [11:0] IDX_RISE_TIME = 12'hC06;
    localparam logic [11:0] IDX_FALL_TIME = 12'hC08;

    // Control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_DIR_BIT = 1;
    localparam int CTRL_OUTVAL_BIT = 3;
    localparam int CTRL_LEVEL_BIT = 7;

    // Event flag fields
    localparam int FLAG_W = 4;
    localparam int FLAG_PULSE_BIT = 0;
    localparam int FLAG_FALL_BIT = 1;
    localparam int FLAG_RISE_BIT = 2;
    localparam int FLAG_NE_BIT = 3;
    localparam logic [FLAG_W-1:0] FLAG_W1C_MASK = 4'h7;

    // Queue entries
    localparam int QUEUE_DEPTH = 4;
    localparam int EV_W = 2;
    localparam logic [EV_W-1:0] EV_NONE = 2'h0;
    localparam logic [EV_W-1:0] EV_FALL = 2'h1;
    localparam logic [EV_W-1:0] EV_RISE = 2'h2;
    localparam logic [EV_W-1:0] EV_PULSE = 2'h3;

    // Threshold widths and reset values, in ticks
    localparam int SHORT_W = 8;
    localparam int LONG_W = 16;
    localparam logic [SHORT_W-1:0] PULSE_MIN_RST = 8'h19;
    localparam logic [SHORT_W-1:0] PULSE_MAX_RST = 8'hC8;
    localparam logic [LONG_W-1:0] RISE_TIME_RST = 16'h000A;
    localparam logic [LONG_W-1:0] FALL_TIME_RST = 16'h00FA;

endpackage

// ---- core/hpr_meas_if.sv ----
/*
 * Carrier between the receiver and its level timer.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/100ps
interface hpr_meas_if #(
    parameter int RUN_W = hpr_pkg::RUN_W
);
    logic run_en;
    logic level;
    logic rise_edge;
    logic [RUN_W-1:0] run_len;
    logic [RUN_W-1:0] prev_len;

    modport meas (
        input run_en,
        output level,
        output rise_edge,
        output run_len,
        output prev_len
    );

    modport user (
        output run_en,
        input level,
        input rise_edge,
        input run_len,
        input prev_len
    );
endinterface

// ---- core/hpr_level_timer.sv ----
/*
 * Synchronises the hot-plug line and measures how long it has held its
 * current level, in ticks of a fixed prescaler.
 * Assumes a synchronous active-high reset and one core clock.
 */
`timescale 1ns/100ps
module hpr_level_timer #(
    parameter int TICK_CYC = hpr_pkg::TICK_CYC,
    parameter int RUN_W = hpr_pkg::RUN_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Line
    input wire logic line_i,
    // Measurement
    hpr_meas_if.meas m
);
    localparam int PRE_W = $clog2(TICK_CYC + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);

    logic sync1_r, sync2_r, level_r, edge_r;
    logic [PRE_W-1:0] pre_r;
    logic [RUN_W-1:0] run_r, prev_r;

    wire tick = (pre_r == PRE_LAST);
    wire changed = (sync2_r != level_r);
    wire run_full = (run_r == {RUN_W{1'b1}});

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            level_r <= 1'b0;
        end else begin
            sync1_r <= line_i;
            sync2_r <= sync1_r;
            level_r <= sync2_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || tick) begin
            pre_r <= '0;
        end else begin
            pre_r <= pre_r + 1'b1;
        end
    end

    // Run length restarts on each level change
    always_ff @(posedge clk_i) begin
        if (rst_i || !m.run_en) begin
            run_r <= '0;
            prev_r <= '0;
            edge_r <= 1'b0;
        end else if (changed) begin
            run_r <= '0;
            prev_r <= run_r;
            edge_r <= sync2_r;
        end else begin
            edge_r <= 1'b0;
            if (tick && !run_full) begin
                run_r <= run_r + 1'b1;
            end
        end
    end

    assign m.level = level_r;
    assign m.rise_edge = edge_r;
    assign m.run_len = run_r;
    assign m.prev_len = prev_r;
endmodule // hpr_level_timer

// ---- core/hpr_receiver.sv ----
/*
 * Hot-plug detect receiver: classifies the hot-plug line into debounced
 * rises, debounced falls and short pulses, keeps the logical plug state,
 * raises event flags into a summary interrupt and records events in a
 * four-entry queue. Registers sit on an AHB-Lite slave.
 * Assumes a 10 MHz clock, synchronous active-high reset, one bus slave,
 * single word transfers only.
 */
// Notes on behaviour
// - Plug state stays high during pulse, low debouncing
// - Plug state drops after 2 ms low
// - Glitches leave plug state unchanged
// - Pulse is fall then rise 250us-2ms later
// - Monitor only when enabled and direction input
// - Low between min and max sets pulse flag
// - High for rise time sets rise flag
// - Low for fall time sets fall flag
// - Disabling clears all event flags
// - Set and unmasked flag raises summary interrupt
// - Queue holds up to four events
// - Queue records only when enabled as input
// - Control register shows pin level read-only, while enabled
// - Each event sets its flag; queued only if queue not full
// - Flags report not-empty, rise, fall, pulse
// - Queue write clears valid entries
// - Control bit1 direction, bit0 enable
// - Queue read clears not-empty flag
`timescale 1ns/100ps
module hpr_receiver #(
    parameter int QUEUE_DEPTH = hpr_pkg::QUEUE_DEPTH,
    parameter int TICK_CYC = hpr_pkg::TICK_CYC,
    parameter int PLUG_LOSS_TICKS = hpr_pkg::PLUG_LOSS_TICKS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Hot-plug line
    input wire logic plug_pin_i,
    // Status out
    output logic hot_plug_summary_irq_o,
    output logic logical_plug_state_o
);
    localparam int RUN_W = hpr_pkg::RUN_W;
    localparam int FW = hpr_pkg::FLAG_W;
    localparam int EW = hpr_pkg::EV_W;
    localparam int CNT_W = $clog2(QUEUE_DEPTH + 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(QUEUE_DEPTH);
    localparam logic [RUN_W-1:0] LOSS_LEN = RUN_W'(PLUG_LOSS_TICKS);
    localparam int PAD_S = RUN_W - hpr_pkg::SHORT_W;
    localparam int PAD_L = RUN_W - hpr_pkg::LONG_W;

    // Bus state
    logic act_r;
    logic wr_r;
    logic ok_r;
    logic [11:0] idx_r;
    logic [31:0] rdata_r;
    logic ready_r;

    // Registers
    logic en_r;
    logic dir_r;
    logic outval_r;
    logic [FW-1:0] flags_r, flags_nxt;
    logic [FW-1:0] mask_r;
    logic [hpr_pkg::SHORT_W-1:0] pmin_r, pmax_r;
    logic [hpr_pkg::LONG_W-1:0] rise_t_r, fall_t_r;

    // Detection and queue state
    logic stable_r, stable_nxt;
    logic plug_r, plug_nxt;
    logic irq_r;
    logic [EW-1:0] q_r [QUEUE_DEPTH];
    logic [CNT_W-1:0] q_cnt_r;
    logic [EW*QUEUE_DEPTH-1:0] q_word;
    logic [31:0] rd_mux;

    hpr_meas_if #(.RUN_W(RUN_W)) meas ();

    hpr_level_timer #(
        .TICK_CYC(TICK_CYC),
        .RUN_W(RUN_W)
    ) i_hpr_level_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .line_i(plug_pin_i),
        .m(meas)
    );

    // Address phase accept and decode
    wire addr_phase = hsel_i && htrans_i[hpr_pkg::HTRANS_ACTIVE_BIT]
                      && hready_i;
    wire addr_ok = (haddr_i[31:14] == 18'h00000) && (haddr_i[1:0] == 2'h0)
                   && (hsize_i == hpr_pkg::HSIZE_WORD);
    wire wr_go = act_r && wr_r && ok_r;
    wire rd_go = act_r && !wr_r;
    wire sel_ctrl = ok_r && (idx_r == hpr_pkg::IDX_CTRL);
    wire sel_flags = ok_r && (idx_r == hpr_pkg::IDX_FLAGS);
    wire sel_mask = ok_r && (idx_r == hpr_pkg::IDX_MASK);
    wire sel_queue = ok_r && (idx_r == hpr_pkg::IDX_QUEUE);
    wire sel_pmin = ok_r && (idx_r == hpr_pkg::IDX_PULSE_MIN);
    wire sel_pmax = ok_r && (idx_r == hpr_pkg::IDX_PULSE_MAX);
    wire sel_rise = ok_r && (idx_r == hpr_pkg::IDX_RISE_TIME);
    wire sel_fall = ok_r && (idx_r == hpr_pkg::IDX_FALL_TIME);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_r <= 1'b0;
            wr_r <= 1'b0;
            ok_r <= 1'b0;
            idx_r <= '0;
        end else begin
            act_r <= addr_phase && !rd_go;
            wr_r <= hwrite_i;
            ok_r <= addr_ok;
            idx_r <= haddr_i[13:2];
        end
    end

    // Reads take one wait state so data reflect any write just before
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_r <= 1'b1;
            rdata_r <= '0;
        end else begin
            ready_r <= !(addr_phase && !hwrite_i && !rd_go);
            if (rd_go) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // Control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_r <= 1'b0;
            dir_r <= 1'b0;
            outval_r <= 1'b0;
        end else if (wr_go && sel_ctrl) begin
            en_r <= hwdata_i[hpr_pkg::CTRL_EN_BIT];
            dir_r <= hwdata_i[hpr_pkg::CTRL_DIR_BIT];
            outval_r <= hwdata_i[hpr_pkg::CTRL_OUTVAL_BIT];
        end
    end

    // Mask and thresholds
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_r <= '0;
            pmin_r <= hpr_pkg::PULSE_MIN_RST;
            pmax_r <= hpr_pkg::PULSE_MAX_RST;
            rise_t_r <= hpr_pkg::RISE_TIME_RST;
            fall_t_r <= hpr_pkg::FALL_TIME_RST;
        end else if (wr_go) begin
            if (sel_mask) begin
                mask_r <= hwdata_i[FW-1:0];
            end
            if (sel_pmin) begin
                pmin_r <= hwdata_i[hpr_pkg::SHORT_W-1:0];
            end
            if (sel_pmax) begin
                pmax_r <= hwdata_i[hpr_pkg::SHORT_W-1:0];
            end
            if (sel_rise) begin
                rise_t_r <= hwdata_i[hpr_pkg::LONG_W-1:0];
            end
            if (sel_fall) begin
                fall_t_r <= hwdata_i[hpr_pkg::LONG_W-1:0];
            end
        end
    end

    // Line classification
    wire listen = en_r && !dir_r;
    assign meas.run_en = listen;
    wire [RUN_W-1:0] pmin_l = {{PAD_S{1'b0}}, pmin_r};
    wire [RUN_W-1:0] pmax_l = {{PAD_S{1'b0}}, pmax_r};
    wire [RUN_W-1:0] rise_l = {{PAD_L{1'b0}}, rise_t_r};
    wire [RUN_W-1:0] fall_l = {{PAD_L{1'b0}}, fall_t_r};

    // Debounced rise after a confirmed low
    wire rise_ev = listen && meas.level && !stable_r
                   && (meas.run_len >= rise_l);
    // Debounced fall after a confirmed high
    wire fall_ev = listen && !meas.level && stable_r
                   && (meas.run_len >= fall_l);
    // Short low pulse closed by a rise within the window
    wire pulse_ev = listen && meas.rise_edge && stable_r
                    && (meas.prev_len >= pmin_l)
                    && (meas.prev_len <= pmax_l);
    wire loss_ev = listen && !meas.level && plug_r
                   && (meas.run_len >= LOSS_LEN);

    always_comb begin
        stable_nxt = stable_r;
        if (!listen) begin
            stable_nxt = 1'b0;
        end else if (rise_ev) begin
            stable_nxt = 1'b1;
        end else if (fall_ev) begin
            stable_nxt = 1'b0;
        end
    end

    // Plug state ignores pulses and stays low until a rise is debounced
    always_comb begin
        plug_nxt = plug_r;
        if (!listen) begin
            plug_nxt = 1'b0;
        end else if (rise_ev) begin
            plug_nxt = 1'b1;
        end else if (loss_ev) begin
            plug_nxt = 1'b0;
        end
    end

    // Event queue, oldest entry at index zero
    wire [EW-1:0] ev_code = pulse_ev ? hpr_pkg::EV_PULSE
                          : rise_ev ? hpr_pkg::EV_RISE
                          : fall_ev ? hpr_pkg::EV_FALL
                          : hpr_pkg::EV_NONE;
    wire ev_any = (ev_code != hpr_pkg::EV_NONE);
    wire q_clear = wr_go && sel_queue;
    wire q_room = q_clear || (q_cnt_r != CNT_FULL);
    wire push = listen && ev_any && q_room;
    wire q_read = rd_go && sel_queue;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_cnt_r <= '0;
            for (int i = 0; i < QUEUE_DEPTH; i++) begin
                q_r[i] <= hpr_pkg::EV_NONE;
            end
        end else if (q_clear) begin
            q_cnt_r <= push ? CNT_W'(1) : '0;
            q_r[0] <= ev_code;
        end else if (push) begin
            q_r[q_cnt_r[CNT_W-2:0]] <= ev_code;
            q_cnt_r <= q_cnt_r + 1'b1;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < QUEUE_DEPTH; gi++) begin : g_qword
            assign q_word[EW*gi +: EW] = (CNT_W'(gi) < q_cnt_r) ? q_r[gi]
                                         : hpr_pkg::EV_NONE;
        end
    endgenerate

    // Event flags: hardware set wins over a same-cycle clear
    wire [FW-1:0] flag_set = {push, rise_ev, fall_ev, pulse_ev};
    wire [FW-1:0] flag_w1c = (wr_go && sel_flags)
                             ? (hwdata_i[FW-1:0] & hpr_pkg::FLAG_W1C_MASK)
                             : '0;
    wire [FW-1:0] flag_rc = q_read ? (FW'(1) << hpr_pkg::FLAG_NE_BIT)
                            : '0;

    always_comb begin
        flags_nxt = (flags_r & ~(flag_w1c | flag_rc)) | flag_set;
        if (!en_r) begin
            flags_nxt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_r <= '0;
            stable_r <= 1'b0;
            plug_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            stable_r <= stable_nxt;
            plug_r <= plug_nxt;
            irq_r <= |(flags_nxt & mask_r);
        end
    end

    // Read data selection
    wire level_vis = en_r && meas.level;
    logic [7:0] ctrl_rd;

    always_comb begin
        ctrl_rd = '0;
        ctrl_rd[hpr_pkg::CTRL_EN_BIT] = en_r;
        ctrl_rd[hpr_pkg::CTRL_DIR_BIT] = dir_r;
        ctrl_rd[hpr_pkg::CTRL_OUTVAL_BIT] = outval_r && dir_r;
        ctrl_rd[hpr_pkg::CTRL_LEVEL_BIT] = level_vis;
    end

    always_comb begin
        rd_mux = '0;
        if (sel_ctrl) begin
            rd_mux[7:0] = ctrl_rd;
        end else if (sel_flags) begin
            rd_mux[FW-1:0] = flags_r;
        end else if (sel_mask) begin
            rd_mux[FW-1:0] = mask_r;
        end else if (sel_queue) begin
            rd_mux[EW*QUEUE_DEPTH-1:0] = q_word;
        end else if (sel_pmin) begin
            rd_mux[hpr_pkg::SHORT_W-1:0] = pmin_r;
        end else if (sel_pmax) begin
            rd_mux[hpr_pkg::SHORT_W-1:0] = pmax_r;
        end else if (sel_rise) begin
            rd_mux[hpr_pkg::LONG_W-1:0] = rise_t_r;
        end else if (sel_fall) begin
            rd_mux[hpr_pkg::LONG_W-1:0] = fall_t_r;
        end
    end

    // Response is always OKAY
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hresp_o <= 1'b0;
        end else begin
            hresp_o <= 1'b0;
        end
    end

    assign hrdata_o = rdata_r;
    assign hreadyout_o = ready_r;
    assign hot_plug_summary_irq_o = irq_r;
    assign logical_plug_state_o = plug_r;

endmodule // hpr_receiver

// ---- test/hpr_line_model.sv ----
/*
 * Display-side model driving the hot-plug line.
 * Assumes a push-pull line: it is always driven, never released.
 */
`timescale 1ns/100ps
module hpr_line_model #(
    parameter int TICK_CYC = 4
) (
    // Clock
    input wire logic clk_i,
    // Line
    output logic plug_pin_o
);
    initial plug_pin_o = 1'h0;
    // Holds a level for whole ticks, changed just after an edge
    task automatic drive(input logic lvl, input int ticks);
        @(posedge clk_i);
        plug_pin_o <= lvl;
        repeat (ticks * TICK_CYC) @(posedge clk_i);
    endtask
endmodule // hpr_line_model

// ---- test/hpr_receiver_properties.sv ----
/*
 * Port checker for hpr_receiver, bound to the receiver module.
 * Assumes one clock, synchronous active-high reset.
 */
`timescale 1ns/100ps
module hpr_receiver_chk #(
    parameter int QUEUE_DEPTH = hpr_pkg::QUEUE_DEPTH,
    parameter int TICK_CYC = hpr_pkg::TICK_CYC,
    parameter int PLUG_LOSS_TICKS = hpr_pkg::PLUG_LOSS_TICKS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Line and status
    input wire logic plug_pin_i,
    input wire logic hot_plug_summary_irq_o,
    input wire logic logical_plug_state_o
);
    localparam int LOSS_MIN = (PLUG_LOSS_TICKS - 1) * TICK_CYC;
    localparam int HOLD_MAX = (PLUG_LOSS_TICKS - 2) * TICK_CYC;
    logic ctrl_wr_r, en_r, mon_r;
    logic [2:0] dis_cnt_r;
    logic [15:0] low_cnt_r;
    wire acc = hsel_i && htrans_i[1] && hready_i;

    // Mirror of the control bits and of the line's low time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_wr_r <= 1'h0;
            en_r <= 1'h0;
            mon_r <= 1'h0;
            dis_cnt_r <= 3'h0;
            low_cnt_r <= 16'h0;
        end else begin
            ctrl_wr_r <= acc && hwrite_i
                && haddr_i[13:2] == hpr_pkg::IDX_CTRL;
            if (ctrl_wr_r) begin
                en_r <= hwdata_i[0];
                mon_r <= hwdata_i[0] && !hwdata_i[1];
            end
            if (en_r)
                dis_cnt_r <= 3'h0;
            else if (dis_cnt_r != 3'h7)
                dis_cnt_r <= dis_cnt_r + 3'h1;
            if (plug_pin_i)
                low_cnt_r <= 16'h0;
            else if (low_cnt_r != 16'hFFFF)
                low_cnt_r <= low_cnt_r + 16'h1;
        end
    end

    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_okay;
        !hresp_o;
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus response not OKAY");
    property p_rd_wait;
        acc && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o;
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read wait state wrong");
    property p_wr_ready;
        acc && hwrite_i |=> hreadyout_o;
    endproperty
    a_wr_ready: assert property (p_wr_ready)
        else $error("write stalled");
    property p_rd_stable;
        !$stable(hrdata_o) |-> !$past(hreadyout_o) || $past(rst_i);
    endproperty
    a_rd_stable: assert property (p_rd_stable)
        else $error("read data moved without a read");
    property p_rst_vals;
        $fell(rst_i) |-> hreadyout_o && !hot_plug_summary_irq_o
            && !logical_plug_state_o && hrdata_o == 32'h0;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("bad outputs after reset");
    property p_dis_irq;
        dis_cnt_r >= 3'h3 |-> !hot_plug_summary_irq_o;
    endproperty
    a_dis_irq: assert property (p_dis_irq)
        else $error("interrupt while disabled");
    property p_loss;
        $fell(logical_plug_state_o) |-> int'(low_cnt_r) >= LOSS_MIN || !mon_r;
    endproperty
    a_loss: assert property (p_loss)
        else $error("plug state dropped early");
    property p_hold;
        logical_plug_state_o && mon_r && !ctrl_wr_r
            && int'(low_cnt_r) < HOLD_MAX |=> logical_plug_state_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("plug state lost during short low");
    property p_rise_src;
        $rose(logical_plug_state_o) |-> mon_r && low_cnt_r < 16'h5;
    endproperty
    a_rise_src: assert property (p_rise_src)
        else $error("plug state rose without high line");
    property p_irq_en;
        $rose(hot_plug_summary_irq_o) |-> en_r || $past(en_r);
    endproperty
    a_irq_en: assert property (p_irq_en)
        else $error("interrupt rose while disabled");
endmodule // hpr_receiver_chk

bind hpr_receiver hpr_receiver_chk #(
    .QUEUE_DEPTH(QUEUE_DEPTH),
    .TICK_CYC(TICK_CYC),
    .PLUG_LOSS_TICKS(PLUG_LOSS_TICKS)
) i_hpr_receiver_chk (
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .plug_pin_i(plug_pin_i),
    .hot_plug_summary_irq_o(hot_plug_summary_irq_o),
    .logical_plug_state_o(logical_plug_state_o)
);

// ---- test/hpr_receiver_tb_top.sv ----
/*
 * Self-checking bench for hpr_receiver: registers, line events, queue.
 * Assumes the line model and the bound port checker.
 */
`timescale 1ns/100ps
module hpr_receiver_tb_top;
    localparam int TCK = 4;
    localparam int LIMIT = 9000;
    localparam logic [11:0] A_CTL = hpr_pkg::IDX_CTRL;
    localparam logic [11:0] A_FLG = hpr_pkg::IDX_FLAGS;
    localparam logic [11:0] A_MSK = hpr_pkg::IDX_MASK;
    localparam logic [11:0] A_QUE = hpr_pkg::IDX_QUEUE;
    localparam logic [31:0] F_P = 32'h1 << hpr_pkg::FLAG_PULSE_BIT;
    localparam logic [31:0] F_F = 32'h1 << hpr_pkg::FLAG_FALL_BIT;
    localparam logic [31:0] F_R = 32'h1 << hpr_pkg::FLAG_RISE_BIT;
    localparam logic [31:0] F_N = 32'h1 << hpr_pkg::FLAG_NE_BIT;
    logic clk_i = 1'h0, rst_i = 1'h1;
    logic hsel_i = 1'h0, hwrite_i = 1'h0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic [31:0] hrdata_o;
    logic hreadyout_o, hresp_o;
    logic plug_pin_i;
    logic irq, state;
    int error_cnt = 0;
    int checked = 0, cyc = 0;

    always #50 clk_i = ~clk_i;

    hpr_receiver #(.TICK_CYC(TCK)) i_hpr_receiver (
        .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(hpr_pkg::HSIZE_WORD), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .plug_pin_i(plug_pin_i), .hot_plug_summary_irq_o(irq),
        .logical_plug_state_o(state)
    );
    hpr_line_model #(.TICK_CYC(TCK)) i_hpr_line_model (
        .clk_i(clk_i),
        .plug_pin_o(plug_pin_i)
    );

    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e,
                       input string m);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %h want %h", $time, m, s, e);
        end
    endtask

    task automatic cs(input logic s, input logic e, input string m);
        chk({31'h0, s}, {31'h0, e}, m);
    endtask

    // One single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [11:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        hsel_i <= 1'h1;
        htrans_i <= 2'h2;
        hwrite_i <= wr;
        haddr_i <= {18'h0, idx, 2'h0};
        do @(posedge clk_i); while (hreadyout_o !== 1'h1);
        hsel_i <= 1'h0;
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge clk_i); while (hreadyout_o !== 1'h1);
        rd = hrdata_o;
    endtask

    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus(1'h1, idx, d, x);
    endtask

    task automatic rc(input logic [11:0] idx, input logic [31:0] e,
                      input string m);
        logic [31:0] x;
        bus(1'h0, idx, 32'h0, x);
        chk(x, e, m);
    endtask

    task automatic line(input logic lvl, input int ticks);
        i_hpr_line_model.drive(lvl, ticks);
    endtask

    task automatic t_regs;
        rc(A_CTL, 32'h0, "ctrl rst");
        rc(A_FLG, 32'h0, "flags rst");
        rc(A_MSK, 32'h0, "mask rst");
        rc(A_QUE, 32'h0, "queue rst");
        rc(hpr_pkg::IDX_PULSE_MIN, 32'h19, "min rst");
        rc(hpr_pkg::IDX_PULSE_MAX, 32'hC8, "max rst");
        rc(hpr_pkg::IDX_FALL_TIME, 32'hFA, "fall rst");
        wr(12'hC07, 32'hFFFFFFFF);
        rc(12'hC07, 32'h0, "unmapped");
        wr(hpr_pkg::IDX_PULSE_MIN, 32'h19);
        wr(hpr_pkg::IDX_PULSE_MAX, 32'hC8);
        wr(hpr_pkg::IDX_RISE_TIME, 32'hC);
        rc(hpr_pkg::IDX_RISE_TIME, 32'hC, "rise rw");
        wr(hpr_pkg::IDX_FALL_TIME, 32'hFA);
        wr(A_MSK, 32'hF);
        wr(A_CTL, 32'h1);
        rc(A_CTL, 32'h1, "ctrl low pin");
        $display("test regs done");
    endtask

    task automatic t_connect;
        line(1'h1, 5);
        line(1'h0, 20);
        rc(A_FLG, 32'h0, "glitch flags");
        cs(state, 1'h0, "state debounce");
        line(1'h1, 20);
        rc(A_FLG, F_R | F_N, "rise flags");
        cs(state, 1'h1, "state up");
        cs(irq, 1'h1, "irq rise");
        rc(A_CTL, 32'h81, "ctrl high pin");
        wr(A_FLG, 32'h7);
        rc(A_FLG, F_N, "w1c");
        $display("test connect done");
    endtask

    task automatic t_pulse;
        line(1'h0, 10);
        line(1'h1, 10);
        rc(A_FLG, F_N, "short low");
        wr(A_MSK, F_F);
        line(1'h0, 100);
        cs(state, 1'h1, "state in pulse");
        line(1'h1, 10);
        rc(A_FLG, F_P | F_N, "pulse flags");
        cs(irq, 1'h0, "irq masked");
        wr(A_MSK, F_P);
        repeat (2) @(posedge clk_i);
        cs(irq, 1'h1, "irq unmasked");
        wr(A_MSK, 32'hF);
        wr(A_FLG, 32'h7);
        $display("test pulse done");
    endtask

    task automatic t_unplug;
        line(1'h0, 180);
        cs(state, 1'h1, "state before loss");
        line(1'h0, 50);
        cs(state, 1'h0, "state after loss");
        rc(A_FLG, F_N, "no fall yet");
        line(1'h0, 40);
        rc(A_FLG, F_F | F_N, "fall flags");
        wr(A_FLG, 32'h7);
        $display("test unplug done");
    endtask

    task automatic t_full;
        line(1'h1, 20);
        rc(A_FLG, F_R | F_N, "rise again");
        wr(A_FLG, 32'h7);
        line(1'h0, 100);
        line(1'h1, 10);
        rc(A_FLG, F_P | F_N, "pulse on full");
        rc(A_QUE, {24'h0, hpr_pkg::EV_RISE, hpr_pkg::EV_FALL,
            hpr_pkg::EV_PULSE, hpr_pkg::EV_RISE}, "queue");
        rc(A_FLG, F_P, "ne cleared");
        wr(A_QUE, 32'h0);
        rc(A_QUE, 32'h0, "queue cleared");
        wr(A_FLG, 32'h7);
        rc(A_FLG, 32'h0, "all clear");
        cs(irq, 1'h0, "irq clear");
        $display("test full done");
    endtask

    task automatic t_off;
        logic [31:0] x;
        line(1'h0, 100);
        line(1'h1, 10);
        wr(A_CTL, 32'h0);
        rc(A_FLG, 32'h0, "flags disabled");
        cs(irq, 1'h0, "irq disabled");
        line(1'h0, 100);
        line(1'h1, 10);
        rc(A_FLG, 32'h0, "no detect off");
        rc(A_QUE, {30'h0, hpr_pkg::EV_PULSE}, "queue off");
        wr(A_CTL, 32'h2);
        wr(A_CTL, 32'h3);
        line(1'h0, 100);
        line(1'h1, 10);
        rc(A_FLG, 32'h0, "no detect out");
        rc(A_QUE, {30'h0, hpr_pkg::EV_PULSE}, "queue out");
        bus(1'h0, A_CTL, 32'h0, x);
        chk(x & 32'h7F, 32'h3, "ctrl out");
        $display("test off done");
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        t_regs();
        t_connect();
        t_pulse();
        t_unplug();
        t_full();
        t_off();
        summarize();
    end
endmodule // hpr_receiver_tb_top
